// *** shared/flow_totalizer_pkg.sv ***
// Shared constants, types and register map of the flow totalizer front panel
package flow_totalizer_pkg;
	localparam longint unsigned CLK_HZ = 64'd25_000_000;
	localparam longint unsigned MS_PER_S = 64'd1000;
	localparam longint unsigned LONG_PRESS_MS = 64'd2000;
	localparam longint unsigned QUICK_VIEW_MS = 64'd5000;
	localparam longint unsigned BOOT_SHOW_MS = 64'd1000;
	localparam longint unsigned BLINK_MS = 64'd500;
	// Least times round up, longest times round down
	localparam int unsigned LONG_PRESS_CYC = 32'((CLK_HZ * LONG_PRESS_MS + MS_PER_S - 1) / MS_PER_S);
	localparam int unsigned QUICK_VIEW_CYC = 32'(CLK_HZ * QUICK_VIEW_MS / MS_PER_S);
	localparam int unsigned BOOT_SHOW_CYC = 32'(CLK_HZ * BOOT_SHOW_MS / MS_PER_S);
	localparam int unsigned BLINK_CYC = 32'(CLK_HZ * BLINK_MS / MS_PER_S);

	localparam int TOT_W = 48;
	localparam int BAT_W = 32;
	localparam int CNT_W = 16;
	localparam int CUR_W = 16;
	localparam int CFG_W = 15;

	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_TOT_LO = 5'h08;
	localparam logic [4:0] REG_TOT_HI = 5'h0c;
	localparam logic [4:0] REG_BATCH = 5'h10;
	localparam logic [4:0] REG_STARTS = 5'h14;

	// Cutoff arithmetic in microamps
	localparam logic [31:0] FULL_UA = 32'h00004e20;
	localparam logic [31:0] SPAN4_UA = 32'h00003e80;
	localparam logic [31:0] BASE4_UA = 32'h00000fa0;
	localparam logic [31:0] PCT_DIV = 32'h00000064;

	localparam logic [47:0] DIGIT6_MAX = 48'h0000000f423f;
	localparam logic [47:0] DIGIT12_MAX = 48'h00e8d4a50fff;
	localparam logic [1:0] WIN_TOP = 2'h2;

	typedef struct packed {
		logic periodMode;
		logic freeAccess;
		logic batcherMode;
		logic batPinZeroEn;
		logic totPinZeroEn;
		logic batBtnZeroEn;
		logic totBtnZeroEn;
		logic in4to20;
		logic [6:0] cutoffPct;
	} cfg_s;
	localparam cfg_s CFG_RST = 15'h0000;

	typedef enum logic [2:0] {VIEW_RATE = 3'b001, VIEW_TOTAL = 3'b010, VIEW_BATCH = 3'b100} view_e;
	typedef enum logic [3:0] {P_NONE = 4'b0001, P_TOT = 4'b0010, P_BAT = 4'b0100, P_STARTS = 4'b1000} pend_e;
	typedef enum logic [3:0] {
		MSG_VALUE = 4'h0, MSG_ID = 4'h1, MSG_MENU = 4'h2, MSG_CLEAR = 4'h3,
		MSG_OVER = 4'h4, MSG_UNDER = 4'h5, MSG_STOP = 4'h6, MSG_PLONG = 4'h7,
		MSG_PSHORT = 4'h8, MSG_TOTOV = 4'h9, MSG_BATOV = 4'ha, MSG_THR_LABEL = 4'hb,
		MSG_STARTS_LABEL = 4'hc
	} msg_e;

	typedef struct packed {
		msg_e msg;
		logic [47:0] value;
		logic [1:0] win;
		logic dpLeft;
		logic dpRight;
		logic sumLed;
	} disp_s;
endpackage : flow_totalizer_pkg

// *** src/flow_totalizer_front_panel.sv ***
// Front panel buttons, totalizer, batch counter and display steering of the flow meter
// What this block does
// - Menu entry needs escape held two seconds
// - Enter toggles batch pause/run in batcher mode
// - Counter zeroing: sum held two seconds, enter confirms
// - Show identification first, then measure
// - Out of range shows high or low warning
// - Period view: stop, too long, too short
// - Total overflow alternates warning with maximum
// - Total zeroed by button, pin or bus
// - Button and pin zeroing need enable option
// - Below cutoff rate shown, total frozen
// - Cutoff threshold from percentage and input range
// - Batch overflow alternates warning with maximum
// - Batch zeroed by button, pin or bus
// - Sum steps views; LED off, on, pulsing
// - Batch view only in batcher mode
// - Up/down quick view, five second timeout
// - Threshold edit only with free access
// - Sum then enter clears start count
// - Start count increments on first start only
// - Long batch value pulses left point
// - Long total pages, points mark hidden digits
// - Counting continues inside the menu
module pin_sync #(
	parameter int unsigned HOLD_CYC = 1
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic pin,
	output logic press,
	output logic shortRel,
	output logic longHit
);
	logic [2:0] sh;
	logic level;
	logic [31:0] holdCnt;
	wire agree = sh[1] == sh[2];
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sh <= 3'h0;
			level <= 1'b0;
			holdCnt <= 32'h0;
			press <= 1'b0;
			shortRel <= 1'b0;
			longHit <= 1'b0;
		end else begin
			sh <= {sh[1:0], pin};
			if (agree)
				level <= sh[2];
			press <= agree && sh[2] && !level;
			// A press that already fired its long action gives no short action on release
			shortRel <= agree && !sh[2] && level && holdCnt < HOLD_CYC;
			longHit <= level && holdCnt == HOLD_CYC - 1;
			if (!level)
				holdCnt <= 32'h0;
			else if (holdCnt < HOLD_CYC)
				holdCnt <= holdCnt + 32'h1;
		end
	end
endmodule : pin_sync

module flow_totalizer_front_panel #(
	parameter int unsigned LONG_PRESS_CYC = flow_totalizer_pkg::LONG_PRESS_CYC,
	parameter int unsigned QUICK_VIEW_CYC = flow_totalizer_pkg::QUICK_VIEW_CYC,
	parameter int unsigned BOOT_SHOW_CYC = flow_totalizer_pkg::BOOT_SHOW_CYC,
	parameter int unsigned BLINK_CYC = flow_totalizer_pkg::BLINK_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic escBtn,
	input wire logic enterBtn,
	input wire logic upBtn,
	input wire logic downBtn,
	input wire logic sumBtn,
	input wire logic progInput,
	input wire logic measTick,
	input wire logic [31:0] flowRate,
	input wire logic [15:0] inputCurrent,
	input wire logic overRange,
	input wire logic underRange,
	input wire logic [31:0] periodValue,
	input wire logic [31:0] relayThreshold,
	output flow_totalizer_pkg::disp_s disp,
	output logic menuActive,
	output logic batchRun,
	output logic thresholdEdit
);
	flow_totalizer_pkg::cfg_s cfg;
	flow_totalizer_pkg::view_e view;
	flow_totalizer_pkg::pend_e pend;
	logic [flow_totalizer_pkg::TOT_W-1:0] total;
	logic [flow_totalizer_pkg::BAT_W-1:0] batch;
	logic [flow_totalizer_pkg::CNT_W-1:0] batchStarts;
	logic totOvf, batOvf, batchStarted, booted, blink, quickOn, quickItem;
	logic [1:0] win;
	logic [31:0] bootCnt, blinkCnt, quickCnt;
	logic escShort, escLong, entPress, upPress, dnPress, sumShort, sumLong, progRise;
	logic [31:0] rdMux;

	pin_sync #(.HOLD_CYC(LONG_PRESS_CYC)) escSync (.ref_clk(ref_clk), .rstn(rstn), .pin(escBtn),
		.press(), .shortRel(escShort), .longHit(escLong));
	pin_sync #(.HOLD_CYC(LONG_PRESS_CYC)) sumSync (.ref_clk(ref_clk), .rstn(rstn), .pin(sumBtn),
		.press(), .shortRel(sumShort), .longHit(sumLong));
	pin_sync #(.HOLD_CYC(1)) entSync (.ref_clk(ref_clk), .rstn(rstn), .pin(enterBtn),
		.press(entPress), .shortRel(), .longHit());
	pin_sync #(.HOLD_CYC(1)) upSync (.ref_clk(ref_clk), .rstn(rstn), .pin(upBtn),
		.press(upPress), .shortRel(), .longHit());
	pin_sync #(.HOLD_CYC(1)) dnSync (.ref_clk(ref_clk), .rstn(rstn), .pin(downBtn),
		.press(dnPress), .shortRel(), .longHit());
	pin_sync #(.HOLD_CYC(1)) prgSync (.ref_clk(ref_clk), .rstn(rstn), .pin(progInput),
		.press(progRise), .shortRel(), .longHit());

	// Bus: one wait cycle, then the access completes at the edge waitrequest is seen low
	wire busDone = (read || write) && !waitrequest;
	wire addrOk = address[1:0] == 2'h0;
	wire wrCtrl = busDone && write && address == flow_totalizer_pkg::REG_CTRL;
	wire wrZero = busDone && write && writedata == 32'h0;
	wire busZeroTot = wrZero && (address == flow_totalizer_pkg::REG_TOT_LO ||
		address == flow_totalizer_pkg::REG_TOT_HI);
	wire busZeroBat = wrZero && address == flow_totalizer_pkg::REG_BATCH;

	// Panel is live only in measurement with the menu closed
	wire live = booted && !menuActive;
	wire idle = live && pend == flow_totalizer_pkg::P_NONE;
	wire confirm = live && entPress;
	wire zeroTot = busZeroTot || (confirm && pend == flow_totalizer_pkg::P_TOT) ||
		(progRise && cfg.totPinZeroEn);
	wire zeroBat = busZeroBat || (confirm && pend == flow_totalizer_pkg::P_BAT) ||
		(progRise && cfg.batPinZeroEn);
	wire zeroStarts = confirm && pend == flow_totalizer_pkg::P_STARTS;

	wire [31:0] pctWide = {25'h0, cfg.cutoffPct};
	wire [31:0] cutUa = cfg.in4to20 ? pctWide * flow_totalizer_pkg::SPAN4_UA / flow_totalizer_pkg::PCT_DIV +
		flow_totalizer_pkg::BASE4_UA : pctWide * flow_totalizer_pkg::FULL_UA / flow_totalizer_pkg::PCT_DIV;
	wire cutoffActive = cfg.cutoffPct != 7'h0 && {16'h0, inputCurrent} < cutUa;
	wire addTick = measTick && !cutoffActive;
	wire [48:0] sumTot = {1'b0, total} + {17'h0, flowRate};
	wire [32:0] sumBat = {1'b0, batch} + {1'b0, flowRate};

	wire runGo = idle && !quickOn && entPress && cfg.batcherMode;
	wire firstStart = runGo && !batchRun && !batchStarted;
	wire stepItem = idle && (upPress || dnPress) && view != flow_totalizer_pkg::VIEW_TOTAL;
	wire hasHigher = win == 2'h0 ? total > flow_totalizer_pkg::DIGIT6_MAX :
		win == 2'h1 ? total > flow_totalizer_pkg::DIGIT12_MAX : 1'b0;
	wire quickEnd = quickOn && quickCnt >= QUICK_VIEW_CYC - 1;

	flow_totalizer_pkg::view_e next_view;
	always_comb begin
		next_view = view;
		case (view)
			flow_totalizer_pkg::VIEW_RATE: next_view = flow_totalizer_pkg::VIEW_TOTAL;
			flow_totalizer_pkg::VIEW_TOTAL: next_view = cfg.batcherMode ? flow_totalizer_pkg::VIEW_BATCH :
				flow_totalizer_pkg::VIEW_RATE;
			default: next_view = flow_totalizer_pkg::VIEW_RATE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0;
			cfg <= flow_totalizer_pkg::CFG_RST;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
			if ((read || write) && waitrequest)
				readdata <= !addrOk ? 32'h0 : rdMux;
			if (wrCtrl)
				cfg <= flow_totalizer_pkg::cfg_s'(writedata[flow_totalizer_pkg::CFG_W-1:0]);
		end
	end

	always_comb begin
		case (address)
			flow_totalizer_pkg::REG_CTRL: rdMux = {17'h0, cfg};
			flow_totalizer_pkg::REG_STATUS: rdMux = {14'h0, cutoffActive, booted, batOvf, totOvf, batchStarted,
				batchRun, quickItem, quickOn, menuActive, win, pend, view};
			flow_totalizer_pkg::REG_TOT_LO: rdMux = total[31:0];
			flow_totalizer_pkg::REG_TOT_HI: rdMux = {16'h0, total[47:32]};
			flow_totalizer_pkg::REG_BATCH: rdMux = batch;
			flow_totalizer_pkg::REG_STARTS: rdMux = {16'h0, batchStarts};
			default: rdMux = 32'h0;
		endcase
	end

	// Counters run regardless of menu or prompt state
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			total <= '0;
			totOvf <= 1'b0;
			batch <= '0;
			batOvf <= 1'b0;
		end else begin
			if (zeroTot) begin
				total <= '0;
				totOvf <= 1'b0;
			end else if (addTick && !totOvf) begin
				total <= sumTot[48] ? '1 : sumTot[47:0];
				totOvf <= sumTot[48];
			end
			if (zeroBat) begin
				batch <= '0;
				batOvf <= 1'b0;
			end else if (addTick && batchRun && !batOvf) begin
				batch <= sumBat[32] ? '1 : sumBat[31:0];
				batOvf <= sumBat[32];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			batchRun <= 1'b0;
			batchStarted <= 1'b0;
			batchStarts <= '0;
		end else begin
			if (!cfg.batcherMode)
				batchRun <= 1'b0;
			else if (runGo)
				batchRun <= !batchRun;
			// A start in the zeroing cycle still counts as the first start
			if (firstStart)
				batchStarted <= 1'b1;
			else if (zeroBat)
				batchStarted <= 1'b0;
			if (zeroStarts)
				batchStarts <= '0;
			else if (firstStart)
				batchStarts <= batchStarts + 16'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bootCnt <= 32'h0;
			booted <= 1'b0;
			blinkCnt <= 32'h0;
			blink <= 1'b0;
			menuActive <= 1'b0;
		end else begin
			if (!booted) begin
				bootCnt <= bootCnt + 32'h1;
				booted <= bootCnt >= BOOT_SHOW_CYC - 1;
			end
			blinkCnt <= blinkCnt >= BLINK_CYC - 1 ? 32'h0 : blinkCnt + 32'h1;
			if (blinkCnt >= BLINK_CYC - 1)
				blink <= !blink;
			if (booted && escLong)
				menuActive <= 1'b1;
			else if (escShort)
				menuActive <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			view <= flow_totalizer_pkg::VIEW_RATE;
			pend <= flow_totalizer_pkg::P_NONE;
			win <= 2'h0;
		end else begin
			if (view == flow_totalizer_pkg::VIEW_BATCH && !cfg.batcherMode)
				view <= flow_totalizer_pkg::VIEW_RATE;
			else if (idle && sumShort && !quickOn)
				view <= next_view;
			if (escShort || confirm || menuActive)
				pend <= flow_totalizer_pkg::P_NONE;
			else if (idle && sumShort && quickOn && quickItem)
				pend <= flow_totalizer_pkg::P_STARTS;
			else if (idle && sumLong && view == flow_totalizer_pkg::VIEW_TOTAL && cfg.totBtnZeroEn)
				pend <= flow_totalizer_pkg::P_TOT;
			else if (idle && sumLong && view == flow_totalizer_pkg::VIEW_BATCH && cfg.batBtnZeroEn)
				pend <= flow_totalizer_pkg::P_BAT;
			if (view != flow_totalizer_pkg::VIEW_TOTAL || !(hasHigher || win != 2'h0))
				win <= 2'h0;
			else if (idle && upPress && hasHigher && win != flow_totalizer_pkg::WIN_TOP)
				win <= win + 2'h1;
			else if (idle && dnPress && win != 2'h0)
				win <= win - 2'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			quickOn <= 1'b0;
			quickItem <= 1'b0;
			quickCnt <= 32'h0;
			thresholdEdit <= 1'b0;
		end else begin
			if (stepItem) begin
				quickOn <= 1'b1;
				quickItem <= quickOn && !quickItem;
				quickCnt <= 32'h0;
			end else if (quickEnd || escShort || !idle) begin
				quickOn <= 1'b0;
			end else if (quickOn) begin
				quickCnt <= quickCnt + 32'h1;
			end
			if (!quickOn || escShort)
				thresholdEdit <= 1'b0;
			else if (idle && entPress && !quickItem && cfg.freeAccess)
				thresholdEdit <= 1'b1;
		end
	end

	flow_totalizer_pkg::disp_s next_disp;
	always_comb begin
		next_disp = '0;
		next_disp.win = win;
		next_disp.sumLed = view == flow_totalizer_pkg::VIEW_TOTAL ||
			(view == flow_totalizer_pkg::VIEW_BATCH && blink);
		if (!booted) begin
			next_disp.msg = flow_totalizer_pkg::MSG_ID;
		end else if (menuActive) begin
			next_disp.msg = flow_totalizer_pkg::MSG_MENU;
		end else if (pend != flow_totalizer_pkg::P_NONE) begin
			next_disp.msg = flow_totalizer_pkg::MSG_CLEAR;
		end else if (quickOn) begin
			next_disp.msg = !blink ? flow_totalizer_pkg::MSG_VALUE : quickItem ?
				flow_totalizer_pkg::MSG_STARTS_LABEL : flow_totalizer_pkg::MSG_THR_LABEL;
			next_disp.value = quickItem ? {32'h0, batchStarts} : {16'h0, relayThreshold};
		end else begin
			case (view)
				flow_totalizer_pkg::VIEW_TOTAL: begin
					next_disp.msg = totOvf && blink ? flow_totalizer_pkg::MSG_TOTOV :
						flow_totalizer_pkg::MSG_VALUE;
					next_disp.value = total;
					next_disp.dpLeft = blink && hasHigher;
					next_disp.dpRight = blink && win != 2'h0;
				end
				flow_totalizer_pkg::VIEW_BATCH: begin
					next_disp.msg = batOvf && blink ? flow_totalizer_pkg::MSG_BATOV :
						flow_totalizer_pkg::MSG_VALUE;
					next_disp.value = {16'h0, batch};
					next_disp.dpLeft = blink && {16'h0, batch} > flow_totalizer_pkg::DIGIT6_MAX;
				end
				default: begin
					next_disp.value = {16'h0, cfg.periodMode ? periodValue : flowRate};
					if (overRange)
						next_disp.msg = flow_totalizer_pkg::MSG_OVER;
					else if (underRange)
						next_disp.msg = flow_totalizer_pkg::MSG_UNDER;
					else if (cfg.periodMode && flowRate == 32'h0)
						next_disp.msg = flow_totalizer_pkg::MSG_STOP;
					else if (cfg.periodMode && {16'h0, periodValue} > flow_totalizer_pkg::DIGIT6_MAX)
						next_disp.msg = flow_totalizer_pkg::MSG_PLONG;
					else if (cfg.periodMode && periodValue == 32'h0)
						next_disp.msg = flow_totalizer_pkg::MSG_PSHORT;
					else
						next_disp.msg = flow_totalizer_pkg::MSG_VALUE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			disp <= '{msg: flow_totalizer_pkg::MSG_ID, default: '0};
		else
			disp <= next_disp;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	boot_msg_a: assert property (!booted |=> disp.msg == flow_totalizer_pkg::MSG_ID)
		else $error("identification not shown before measurement");
	menu_entry_a: assert property ($rose(menuActive) |-> $past(escLong))
		else $error("menu entered without long escape press");
	cutoff_hold_a: assert property (measTick && cutoffActive && !zeroTot |=> $stable(total))
		else $error("total moved below cutoff");
	total_add_a: assert property (addTick && !totOvf && !zeroTot && !sumTot[48] |=>
		total == $past(sumTot[47:0]))
		else $error("total did not add the rate");
	zero_total_a: assert property (zeroTot |=> total == '0 && !totOvf)
		else $error("total not zeroed");
	zero_gate_a: assert property ($rose(pend == flow_totalizer_pkg::P_TOT) |-> $past(cfg.totBtnZeroEn))
		else $error("button zeroing offered while disabled");
	batch_toggle_a: assert property (runGo |=> batchRun != $past(batchRun))
		else $error("enter did not toggle batching");
	starts_once_a: assert property (batchStarted && !zeroStarts |=> batchStarts == $past(batchStarts))
		else $error("start count moved on a resume");
	batch_view_a: assert property (view == flow_totalizer_pkg::VIEW_BATCH && !cfg.batcherMode |=>
		view == flow_totalizer_pkg::VIEW_RATE)
		else $error("batch view kept outside batcher mode");
	led_total_a: assert property (view == flow_totalizer_pkg::VIEW_TOTAL |=> disp.sumLed)
		else $error("sum LED dark in total view");

	zero_seen_c: cover property (confirm && pend == flow_totalizer_pkg::P_TOT);
	quick_seen_c: cover property ($rose(quickOn) ##[1:20] stepItem);
	start_seen_c: cover property (firstStart);
	page_seen_c: cover property (win == flow_totalizer_pkg::WIN_TOP);
endmodule : flow_totalizer_front_panel

// *** dv/panel_operator.sv ***
// Operator model that works the front panel buttons and the programmable input
module panel_operator (
	input wire logic ref_clk,
	output logic [5:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pin order: escape, enter, up, down, sum, programmable input
	initial pins = 6'h00;
	// Holds and idle gaps stay well above the three-flop synchroniser depth
	task automatic push(input int b, input int n);
		pins[b] <= 1'b1;
		repeat (n) @(posedge ref_clk);
		pins[b] <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask : push
endmodule : panel_operator

// *** dv/tb.sv ***
// Self-checking bench of the flow totalizer front panel
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errorCnt++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LP = 20;
	logic ref_clk = 0, rstn = 0, read = 0, write = 0, measTick = 0, overRange = 0, underRange = 0;
	logic waitrequest, menuActive, batchRun, thresholdEdit;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 0, flowRate = 0, periodValue = 1, relayThreshold = 32'h1234, rdv, readdata;
	logic [15:0] inputCurrent = 0;
	logic [5:0] pins;
	int seed = 32'h6e96;
	logic [5:0] dots;
	logic [1:0] sn;
	logic [47:0] tot = 0;
	logic [31:0] batch_source_option = 0;
	int errorCnt = 0, checked = 0;
	flow_totalizer_pkg::disp_s disp;
	logic [1:0] rng[5] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
	logic [31:0] flw[5] = '{5, 5, 0, 5, 5};
	logic [31:0] per[5] = '{1, 1, 1, 1000000, 0};
	flow_totalizer_pkg::msg_e xm[5] = '{flow_totalizer_pkg::MSG_OVER, flow_totalizer_pkg::MSG_UNDER,
		flow_totalizer_pkg::MSG_STOP, flow_totalizer_pkg::MSG_PLONG, flow_totalizer_pkg::MSG_PSHORT};
	logic [2:0] vs[3] = '{3'h2, 3'h4, 3'h1};
	always #20 ref_clk = ~ref_clk;
	flow_totalizer_front_panel #(.LONG_PRESS_CYC(LP), .QUICK_VIEW_CYC(50), .BOOT_SHOW_CYC(10), .BLINK_CYC(4))
	flow_totalizer_front_panel_inst (.ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.escBtn(pins[0]), .enterBtn(pins[1]), .upBtn(pins[2]), .downBtn(pins[3]), .sumBtn(pins[4]),
		.progInput(pins[5]), .measTick(measTick), .flowRate(flowRate), .inputCurrent(inputCurrent),
		.overRange(overRange), .underRange(underRange), .periodValue(periodValue),
		.relayThreshold(relayThreshold), .disp(disp), .menuActive(menuActive), .batchRun(batchRun),
		.thresholdEdit(thresholdEdit));
	panel_operator panel_operator_inst (.ref_clk(ref_clk), .pins(pins));
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	// Request held until waitrequest is sampled low; a hung slave ends the run
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do begin @(posedge ref_clk); n++; end while (waitrequest !== 1'b0 && n < 20);
		rdv = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			errorCnt++;
			end_sim();
		end
		@(posedge ref_clk);
	endtask : bus
	task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		`CHK(nm, e, rdv)
	endtask : rc
	task automatic tick(input logic [31:0] r, input logic add);
		flowRate <= r;
		measTick <= 1'b1;
		@(posedge ref_clk);
		measTick <= 1'b0;
		if (add) tot += 48'(r);
		if (add && batchRun === 1'b1) batch_source_option += r;
		repeat (3) @(posedge ref_clk);
	endtask : tick
	function automatic int thr(input int pct, input int r);
		return r ? pct * 16000 / 100 + 4000 : pct * 20000 / 100;
	endfunction : thr
	// Eight samples cover both blink phases; dots holds ever-high then always-high of left, right, LED
	task automatic watch();
		logic [2:0] hi, lo;
		hi = 3'h0;
		lo = 3'h7;
		sn = 2'h0;
		repeat (8) begin
			@(posedge ref_clk);
			hi = hi | {disp.dpLeft, disp.dpRight, disp.sumLed};
			lo = lo & {disp.dpLeft, disp.dpRight, disp.sumLed};
			sn = sn | {disp.msg == flow_totalizer_pkg::MSG_VALUE, disp.msg == flow_totalizer_pkg::MSG_TOTOV ||
				disp.msg == flow_totalizer_pkg::MSG_BATOV};
		end
		dots = {hi, lo};
	endtask : watch
	// Back-to-back updates at full rate reach the long totals within the run budget
	task automatic fill(input int n);
		flowRate <= 32'hffffffff;
		measTick <= 1'b1;
		repeat (n) @(posedge ref_clk);
		measTick <= 1'b0;
		@(posedge ref_clk);
	endtask : fill
	initial begin
		repeat (8) @(posedge ref_clk);
		`CHK("bootMsg", flow_totalizer_pkg::MSG_ID, disp.msg)
		rstn <= 1'b1;
		repeat (14) @(posedge ref_clk);
		`CHK("measMsg", flow_totalizer_pkg::MSG_VALUE, disp.msg)
		rc(5'h18, 32'h0, "unmapped");
		rc(5'h01, 32'h0, "misaligned");
		// Quick view opens from rate view, denies threshold edit without free access, then lapses
		panel_operator_inst.push(2, 5);
		rc(flow_totalizer_pkg::REG_STATUS, 32'h0001_0409, "quickOn");
		panel_operator_inst.push(1, 5);
		`CHK("thrEdit", 1'b0, thresholdEdit)
		repeat (60) @(posedge ref_clk);
		rc(flow_totalizer_pkg::REG_STATUS, 32'h0001_0009, "quickOff");
		for (int i = 0; i < 6; i++) tick($random(seed) & 32'h0000ffff, 1'b1);
		rc(flow_totalizer_pkg::REG_TOT_LO, tot[31:0], "totLo");
		rc(flow_totalizer_pkg::REG_TOT_HI, {16'h0, tot[47:32]}, "totHi");
		for (int r = 0; r < 2; r++) begin
			bus(1'b1, flow_totalizer_pkg::REG_CTRL, 32'(r * 128 + 50));
			inputCurrent <= 16'(thr(50, r) - 1);
			tick(32'h321, 1'b0);
			inputCurrent <= 16'(thr(50, r));
			tick(32'h123, 1'b1);
			rc(flow_totalizer_pkg::REG_TOT_LO, tot[31:0], "cutoff");
		end
		bus(1'b1, flow_totalizer_pkg::REG_TOT_LO, 32'h5);
		rc(flow_totalizer_pkg::REG_TOT_LO, tot[31:0], "nzWrite");
		bus(1'b1, flow_totalizer_pkg::REG_TOT_LO, 32'h0);
		tot = 0;
		rc(flow_totalizer_pkg::REG_TOT_LO, 32'h0, "busZero");
		bus(1'b1, flow_totalizer_pkg::REG_CTRL, 32'h0);
		tick(32'h64, 1'b1);
		panel_operator_inst.push(4, 5);
		`CHK("ledTotal", 1'b1, disp.sumLed)
		panel_operator_inst.push(4, LP + 10);
		panel_operator_inst.push(1, 5);
		rc(flow_totalizer_pkg::REG_TOT_LO, tot[31:0], "btnOff");
		bus(1'b1, flow_totalizer_pkg::REG_CTRL, 32'h0000_0500);
		panel_operator_inst.push(4, LP + 10);
		`CHK("prompt", flow_totalizer_pkg::MSG_CLEAR, disp.msg)
		panel_operator_inst.push(1, 5);
		tot = 0;
		rc(flow_totalizer_pkg::REG_TOT_LO, 32'h0, "btnZero");
		tick(32'h4d, 1'b1);
		panel_operator_inst.push(5, 5);
		tot = 0;
		rc(flow_totalizer_pkg::REG_TOT_LO, 32'h0, "pinZero");
		panel_operator_inst.push(4, 5);
		rc(flow_totalizer_pkg::REG_STATUS, 32'h0001_0009, "noBatView");
		`CHK("ledRate", 1'b0, disp.sumLed)
		bus(1'b1, flow_totalizer_pkg::REG_CTRL, 32'h0000_1000);
		for (int i = 0; i < 3; i++) begin
			panel_operator_inst.push(4, 5);
			bus(1'b0, flow_totalizer_pkg::REG_STATUS, 32'h0);
			`CHK("view", vs[i], rdv[2:0])
		end
		for (int i = 0; i < 3; i++) begin
			panel_operator_inst.push(1, 5);
			`CHK("batchRun", (i % 2 == 0), batchRun)
			tick($random(seed) & 32'h00000fff, 1'b1);
		end
		rc(flow_totalizer_pkg::REG_STARTS, 32'h1, "starts");
		rc(flow_totalizer_pkg::REG_BATCH, batch_source_option, "batch");
		panel_operator_inst.push(0, 5);
		`CHK("escShort", 1'b0, menuActive)
		panel_operator_inst.push(0, LP + 10);
		`CHK("menu", 1'b1, menuActive)
		tick(32'h99, 1'b1);
		rc(flow_totalizer_pkg::REG_TOT_LO, tot[31:0], "menuCount");
		rc(flow_totalizer_pkg::REG_BATCH, batch_source_option, "menuBatch");
		panel_operator_inst.push(0, 5);
		bus(1'b1, flow_totalizer_pkg::REG_BATCH, 32'h0);
		rc(flow_totalizer_pkg::REG_BATCH, 32'h0, "batZero");
		bus(1'b1, flow_totalizer_pkg::REG_CTRL, 32'h0000_3a00);
		panel_operator_inst.push(2, 5);
		`CHK("thrValue", 48'h1234, disp.value)
		panel_operator_inst.push(1, 5);
		`CHK("thrGrant", 1'b1, thresholdEdit)
		panel_operator_inst.push(3, 5);
		`CHK("startsValue", 48'h1, disp.value)
		panel_operator_inst.push(4, 5);
		`CHK("startsPrompt", flow_totalizer_pkg::MSG_CLEAR, disp.msg)
		panel_operator_inst.push(1, 5);
		rc(flow_totalizer_pkg::REG_STARTS, 32'h0, "startsZero");
		panel_operator_inst.push(4, 5);
		panel_operator_inst.push(4, 5);
		tick(32'h000f4240, 1'b1);
		watch();
		`CHK("batDots", 6'h28, dots)
		tick(32'hffffffff, 1'b1);
		watch();
		`CHK("batOvMsg", 2'h3, sn)
		rc(flow_totalizer_pkg::REG_BATCH, 32'hffffffff, "batMax");
		panel_operator_inst.push(5, 5);
		rc(flow_totalizer_pkg::REG_BATCH, 32'h0, "batPinZero");
		tick(32'h10, 1'b1);
		panel_operator_inst.push(4, LP + 10);
		panel_operator_inst.push(1, 5);
		rc(flow_totalizer_pkg::REG_BATCH, 32'h0, "batBtnZero");
		panel_operator_inst.push(4, 5);
		panel_operator_inst.push(4, 5);
		fill(300);
		watch();
		`CHK("win0Dots", 6'h29, dots)
		panel_operator_inst.push(2, 5);
		watch();
		`CHK("win1", 2'h1, disp.win)
		`CHK("win1Dots", 6'h39, dots)
		panel_operator_inst.push(2, 5);
		panel_operator_inst.push(2, 5);
		watch();
		`CHK("win2", 2'h2, disp.win)
		`CHK("win2Dots", 6'h19, dots)
		panel_operator_inst.push(3, 5);
		`CHK("winDown", 2'h1, disp.win)
		fill(65400);
		watch();
		`CHK("totOvMsg", 2'h3, sn)
		rc(flow_totalizer_pkg::REG_TOT_HI, 32'h0000ffff, "totMax");
		rc(flow_totalizer_pkg::REG_TOT_LO, 32'hffffffff, "totMaxLo");
		bus(1'b1, flow_totalizer_pkg::REG_TOT_HI, 32'h0);
		rc(flow_totalizer_pkg::REG_TOT_LO, 32'h0, "hiZero");
		panel_operator_inst.push(4, 5);
		bus(1'b1, flow_totalizer_pkg::REG_CTRL, 32'h0000_4000);
		for (int i = 0; i < 5; i++) begin
			{overRange, underRange} <= rng[i];
			flowRate <= flw[i];
			periodValue <= per[i];
			repeat (6) @(posedge ref_clk);
			`CHK("rangeMsg", xm[i], disp.msg)
		end
		end_sim();
	end
	initial begin
		repeat (90000) @(posedge ref_clk);
		errorCnt++;
		end_sim();
	end
endmodule : tb
